// *** design/msr_pkg.sv ***
// Package for the monitor and status register bank: map, fields, types
package msr_pkg;

  // Byte offsets
  localparam logic [7:0] MSR_OFF_TEMP = 8'h60;
  localparam logic [7:0] MSR_OFF_SUPPLY = 8'h62;
  localparam logic [7:0] MSR_OFF_MONITOR_INPUT_ONE = 8'h64;
  localparam logic [7:0] MSR_OFF_MONITOR_INPUT_TWO = 8'h66;
  localparam logic [7:0] MSR_OFF_MONITOR_INPUT_THREE = 8'h68;
  localparam logic [7:0] MSR_OFF_MONITOR_INPUT_FOUR = 8'h6a;
  localparam logic [7:0] MSR_OFF_RSVD = 8'h6c;
  localparam logic [7:0] MSR_OFF_STATUS = 8'h6e;
  localparam logic [7:0] MSR_OFF_UPDATE = 8'h6f;
  localparam logic [7:0] MSR_OFF_ALARM = 8'h70;

  // Status bit positions
  localparam int MSR_ST_TXD_PIN = 7;
  localparam int MSR_ST_TXD_SW = 6;
  localparam int MSR_ST_IN1 = 5;
  localparam int MSR_ST_RATE_SELECT_INPUT_PIN = 4;
  localparam int MSR_ST_RATE_SELECT_INPUT_SW = 3;
  localparam int MSR_ST_TXF = 2;
  localparam int MSR_ST_LOS = 1;
  localparam int MSR_ST_NRDY = 0;

  // Conversion-complete register fields
  localparam int MSR_UPD_TOP = 7;
  localparam int MSR_UPD_RANGE = 0;

  // Reset values
  localparam logic [15:0] MSR_RESULT_RST = 16'h0000;
  localparam logic [7:0] MSR_UPDATE_RST = 8'h00;
  localparam logic [7:0] MSR_ALARM_RST = 8'h10;
  localparam logic [7:0] MSR_RSVD_VALUE = 8'h00;

  // Channel numbering, matching update bit order from the top
  localparam int MSR_NCH = 6;
  localparam logic [2:0] MSR_CH_TEMP = 3'h0;
  localparam logic [2:0] MSR_CH_SUPPLY = 3'h1;
  localparam logic [2:0] MSR_CH_MONITOR_INPUT_THREE = 3'h4;

  typedef struct packed {
    logic valid;
    logic [2:0] channel;
    logic [15:0] value;
    logic coarse_range;
  } msr_conv_t;

  typedef struct packed {
    logic [15:0] hi;
    logic [15:0] lo;
  } msr_thresh_t;

  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } msr_bus_req_t;

  typedef struct packed {
    logic [MSR_NCH-1:0][15:0] result;
    logic tx_disable_sw_force;
    logic rate_select_sw_force;
    logic [MSR_NCH-1:0] conv_done;
    logic receive_power_range_flag;
    logic [7:0] alarm;
    logic [7:0] rdata;
  } msr_state_t;

endpackage : msr_pkg

// *** design/msr_bank.sv ***
// Monitor results, pin status, conversion flags and first alarm register
`timescale 1ns/10ps

module msr_bank
  import msr_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire msr_bus_req_t i_bus,
  output logic [7:0] o_rdata,
  input wire msr_conv_t i_conv,
  input wire msr_thresh_t [MSR_NCH-1:0] i_thresh,
  input wire logic i_tx_disable_pin,
  input wire logic i_digital_input_one,
  input wire logic i_rate_select_input,
  input wire logic i_transmit_fault_drive_low,
  input wire logic i_loss_of_signal_drive_low,
  input wire logic i_below_power_on_trip,
  output logic o_tx_disable_active,
  output logic o_rate_select_output
);

  ////////////////////////////////////////////////////////////////////////////
  // Comparison and index helpers

  function automatic logic exceeds(input logic [15:0] a, input logic [15:0] b,
                                   input logic is_signed);
    if (is_signed) begin
      return $signed(a) > $signed(b);
    end
    return a > b;
  endfunction : exceeds

  // Channel 0 sits at the top flag bit, later channels step downwards
  function automatic int update_bit(input int ch);
    return MSR_UPD_TOP - ch;
  endfunction : update_bit

  // Word index of a result byte; only called for 0x60 to 0x6b
  function automatic logic [2:0] result_index(input logic [7:0] addr);
    logic [7:0] rel;
    rel = addr - MSR_OFF_TEMP;
    return rel[3:1];
  endfunction : result_index

  ////////////////////////////////////////////////////////////////////////////
  // State

  msr_state_t state_reg;
  msr_state_t state_next;
  logic [7:0] status_view;
  logic [7:0] update_view;
  logic conv_hi;
  logic conv_lo;
  logic [15:0] sel_hi;
  logic [15:0] sel_lo;
  logic is_temp;

  always_comb begin
    status_view = '0;
    status_view[MSR_ST_TXD_PIN] = i_tx_disable_pin;
    status_view[MSR_ST_TXD_SW] = state_reg.tx_disable_sw_force;
    status_view[MSR_ST_IN1] = i_digital_input_one;
    status_view[MSR_ST_RATE_SELECT_INPUT_PIN] = i_rate_select_input;
    status_view[MSR_ST_RATE_SELECT_INPUT_SW] = state_reg.rate_select_sw_force;
    status_view[MSR_ST_TXF] = ~i_transmit_fault_drive_low;
    status_view[MSR_ST_LOS] = ~i_loss_of_signal_drive_low;
    status_view[MSR_ST_NRDY] = i_below_power_on_trip;
    update_view = '0;
    for (int c = 0; c < MSR_NCH; c++) begin
      update_view[update_bit(c)] = state_reg.conv_done[c];
    end
    update_view[MSR_UPD_RANGE] = state_reg.receive_power_range_flag;
  end

  assign sel_hi = i_thresh[i_conv.channel].hi;
  assign sel_lo = i_thresh[i_conv.channel].lo;
  assign is_temp = (i_conv.channel == MSR_CH_TEMP);
  assign conv_hi = exceeds(i_conv.value, sel_hi, is_temp);
  assign conv_lo = exceeds(sel_lo, i_conv.value, is_temp);

  always_comb begin
    state_next = state_reg;
    // Host write first, so a conversion in the same cycle wins
    if (i_bus.wr_en) begin
      unique case (i_bus.addr)
        MSR_OFF_STATUS: begin
          // Only the two override bits take writes
          state_next.tx_disable_sw_force = i_bus.wdata[MSR_ST_TXD_SW];
          state_next.rate_select_sw_force = i_bus.wdata[MSR_ST_RATE_SELECT_INPUT_SW];
        end
        MSR_OFF_UPDATE: begin
          for (int c = 0; c < MSR_NCH; c++) begin
            state_next.conv_done[c] = state_reg.conv_done[c]
                                      & i_bus.wdata[update_bit(c)];
          end
        end
        default: begin
          // Results, reserved and alarm bytes ignore writes
        end
      endcase
    end
    if (i_conv.valid && (int'(i_conv.channel) < MSR_NCH)) begin
      state_next.result[i_conv.channel] = i_conv.value;
      state_next.conv_done[i_conv.channel] = 1'b1;
      if (i_conv.channel == MSR_CH_MONITOR_INPUT_THREE) begin
        state_next.receive_power_range_flag = i_conv.coarse_range;
      end
      if (i_conv.channel <= 3'h3) begin
        // Alarm pair for channel c sits at bits 7-2c and 6-2c
        state_next.alarm[7 - 2*int'(i_conv.channel)] = conv_hi;
        state_next.alarm[6 - 2*int'(i_conv.channel)] = conv_lo;
      end
    end
    // Low supply forces the low alarm regardless of measurement
    if (i_below_power_on_trip) begin
      state_next.alarm[4] = 1'b1;
    end
    if (i_bus.rd_en) begin
      unique case (i_bus.addr)
        MSR_OFF_TEMP, MSR_OFF_SUPPLY, MSR_OFF_MONITOR_INPUT_ONE, MSR_OFF_MONITOR_INPUT_TWO,
        MSR_OFF_MONITOR_INPUT_THREE, MSR_OFF_MONITOR_INPUT_FOUR: begin
          state_next.rdata = state_reg.result[result_index(i_bus.addr)][15:8];
        end
        MSR_OFF_TEMP + 8'h01, MSR_OFF_SUPPLY + 8'h01, MSR_OFF_MONITOR_INPUT_ONE + 8'h01,
        MSR_OFF_MONITOR_INPUT_TWO + 8'h01, MSR_OFF_MONITOR_INPUT_THREE + 8'h01, MSR_OFF_MONITOR_INPUT_FOUR + 8'h01: begin
          state_next.rdata = state_reg.result[result_index(i_bus.addr)][7:0];
        end
        MSR_OFF_RSVD, MSR_OFF_RSVD + 8'h01: state_next.rdata = MSR_RSVD_VALUE;
        MSR_OFF_STATUS: state_next.rdata = status_view;
        MSR_OFF_UPDATE: state_next.rdata = update_view;
        MSR_OFF_ALARM: state_next.rdata = state_reg.alarm;
        default: state_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg.result <= '0;
      state_reg.tx_disable_sw_force <= 1'b0;
      state_reg.rate_select_sw_force <= 1'b0;
      state_reg.conv_done <= '0;
      state_reg.receive_power_range_flag <= 1'b0;
      state_reg.alarm <= MSR_ALARM_RST;
      state_reg.rdata <= 8'h00;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign o_rdata = state_reg.rdata;
  assign o_tx_disable_active = i_tx_disable_pin | state_reg.tx_disable_sw_force;
  assign o_rate_select_output = i_rate_select_input | state_reg.rate_select_sw_force;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  AST_WRITE_RESULT_IGNORED: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_bus.wr_en && !i_conv.valid && i_bus.addr >= MSR_OFF_TEMP && i_bus.addr < MSR_OFF_RSVD)
    |=> $stable(state_reg.result))
    else $error("result changed by host write");

  AST_CONV_SETS_FLAG: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_conv.valid && i_conv.channel == MSR_CH_SUPPLY) |=> state_reg.conv_done[1])
    else $error("supply flag not set");

  AST_FLAG_CLEAR: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_bus.wr_en && i_bus.addr == MSR_OFF_UPDATE && i_bus.wdata == 8'h00 && !i_conv.valid)
    |=> state_reg.conv_done == '0)
    else $error("flags not cleared by write");

  AST_TXD_OR: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_bus.wr_en && i_bus.addr == MSR_OFF_STATUS && i_bus.wdata[MSR_ST_TXD_SW])
    |=> o_tx_disable_active)
    else $error("transmit disable force not applied");

  AST_RATE_SELECT_INPUT_OR: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_bus.wr_en && i_bus.addr == MSR_OFF_STATUS && i_bus.wdata[MSR_ST_RATE_SELECT_INPUT_SW])
    |=> o_rate_select_output)
    else $error("rate select force not applied");

  AST_RATE_SELECT_INPUT_PIN: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_rate_select_input |-> o_rate_select_output)
    else $error("rate select pin not passed through");

  AST_TXD_PIN: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_tx_disable_pin |-> o_tx_disable_active)
    else $error("transmit disable pin not passed through");

  AST_OVERRIDE_WRITE: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_bus.wr_en && i_bus.addr == MSR_OFF_STATUS)
    |=> state_reg.tx_disable_sw_force == $past(i_bus.wdata[MSR_ST_TXD_SW]))
    else $error("transmit disable force not written");

  AST_LOW_SUPPLY_ALARM: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_below_power_on_trip |=> state_reg.alarm[4])
    else $error("supply low alarm not set");

  AST_SUPPLY_LOW_HOLD: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (state_reg.alarm[4] && !(i_conv.valid && i_conv.channel == MSR_CH_SUPPLY))
    |=> state_reg.alarm[4])
    else $error("supply low alarm cleared without conversion");

  AST_TEMP_HIGH: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_conv.valid && i_conv.channel == MSR_CH_TEMP
     && $signed(i_conv.value) > $signed(i_thresh[0].hi)) |=> state_reg.alarm[7])
    else $error("temperature high alarm missed");

  AST_STATUS_READ: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_bus.rd_en && i_bus.addr == MSR_OFF_STATUS) |=> o_rdata[7] == $past(i_tx_disable_pin))
    else $error("status pin mirror wrong");

  AST_NOT_READY_READ: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_bus.rd_en && i_bus.addr == MSR_OFF_STATUS)
    |=> o_rdata[0] == $past(i_below_power_on_trip))
    else $error("ready flag mirror wrong");

  AST_FAULT_READ: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_bus.rd_en && i_bus.addr == MSR_OFF_STATUS)
    |=> o_rdata[2] == !$past(i_transmit_fault_drive_low))
    else $error("transmit fault mirror wrong");

  AST_LOS_READ: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_bus.rd_en && i_bus.addr == MSR_OFF_STATUS)
    |=> o_rdata[1] == !$past(i_loss_of_signal_drive_low))
    else $error("loss of signal mirror wrong");

  AST_IN1_READ: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_bus.rd_en && i_bus.addr == MSR_OFF_STATUS)
    |=> o_rdata[5] == $past(i_digital_input_one))
    else $error("input one mirror wrong");

  AST_RESERVED_READ: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_bus.rd_en && (i_bus.addr == MSR_OFF_RSVD || i_bus.addr == MSR_OFF_RSVD + 8'h01))
    |=> o_rdata == MSR_RSVD_VALUE)
    else $error("reserved byte not zero");

  AST_SUPPLY_READ_HIGH: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_bus.rd_en && i_bus.addr == MSR_OFF_SUPPLY)
    |=> o_rdata == $past(state_reg.result[1][15:8]))
    else $error("supply high byte wrong");

  AST_TEMP_READ_LOW: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_bus.rd_en && i_bus.addr == MSR_OFF_TEMP + 8'h01)
    |=> o_rdata == $past(state_reg.result[0][7:0]))
    else $error("temperature fraction byte wrong");

  AST_RESULT_LOAD: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_conv.valid && int'(i_conv.channel) < MSR_NCH)
    |=> state_reg.result[$past(i_conv.channel)] == $past(i_conv.value))
    else $error("result not loaded");

  AST_UPDATE_READ: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_bus.rd_en && i_bus.addr == MSR_OFF_UPDATE)
    |=> o_rdata[0] == $past(state_reg.receive_power_range_flag) && !o_rdata[1])
    else $error("update register low bits wrong");

  AST_RANGE_FLAG: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_conv.valid && i_conv.channel == MSR_CH_MONITOR_INPUT_THREE)
    |=> state_reg.receive_power_range_flag == $past(i_conv.coarse_range))
    else $error("range flag not captured");

  // Only a host write to the flag register may drop a flag
  AST_FLAG_HOLD: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    !(i_bus.wr_en && i_bus.addr == MSR_OFF_UPDATE)
    |=> (state_reg.conv_done & $past(state_reg.conv_done)) == $past(state_reg.conv_done))
    else $error("conversion flag lost without write");

  AST_RDATA_HOLD: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    !i_bus.rd_en |=> $stable(o_rdata))
    else $error("read data moved without read");

  AST_ALARM_READ_ONLY: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_bus.wr_en && i_bus.addr == MSR_OFF_ALARM && !i_conv.valid && !i_below_power_on_trip)
    |=> $stable(state_reg.alarm))
    else $error("alarm register changed by host write");

  AST_TEMP_LOW: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_conv.valid && i_conv.channel == MSR_CH_TEMP
     && $signed(i_conv.value) < $signed(i_thresh[0].lo)) |=> state_reg.alarm[6])
    else $error("temperature low alarm missed");

  AST_SUPPLY_HIGH: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_conv.valid && i_conv.channel == MSR_CH_SUPPLY
     && i_conv.value > i_thresh[1].hi) |=> state_reg.alarm[5])
    else $error("supply high alarm missed");

  AST_SUPPLY_LOW_CLEAR: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_conv.valid && i_conv.channel == MSR_CH_SUPPLY && !i_below_power_on_trip
     && i_conv.value >= i_thresh[1].lo) |=> !state_reg.alarm[4])
    else $error("supply low alarm not cleared");

  AST_MONITOR_INPUT_TWO_LOW: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_conv.valid && i_conv.channel == 3'h3
     && i_conv.value < i_thresh[3].lo) |=> state_reg.alarm[0])
    else $error("monitor two low alarm missed");

  AST_MONITOR_INPUT_ONE_HIGH: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_conv.valid && i_conv.channel == 3'h2
     && i_conv.value > i_thresh[2].hi) |=> state_reg.alarm[3])
    else $error("monitor one high alarm missed");

endmodule : msr_bank

// *** tb/msr_host.sv ***
// Host model issuing register reads and writes to the bank
`timescale 1ns/10ps
module msr_host
  import msr_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic [7:0] i_rdata,
  output msr_bus_req_t o_bus
);
  initial o_bus = '0;
  // Released fields flip so a stale address is never mistaken for live
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    o_bus <= '{1'b1, 1'b0, a, d};
    @(posedge i_ref_clk);
    o_bus <= '{1'b0, 1'b0, ~a, ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_ref_clk);
    o_bus <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge i_ref_clk);
    o_bus <= '{1'b0, 1'b0, ~a, 8'hff};
    #1;
    d = i_rdata;
  endtask : rd
endmodule : msr_host

// *** tb/msr_bank_tb.sv ***
// Self-checking bench for the monitor and status register bank
`timescale 1ns/10ps
module msr_bank_tb;
  import msr_pkg::*;
  logic i_ref_clk, i_rstn, txd, in1, rate_select_input, txf_lo, los_lo, below, o_txd, o_rs;
  msr_bus_req_t bus;
  msr_conv_t conv;
  msr_thresh_t [MSR_NCH-1:0] thr;
  logic [7:0] rdata;
  int num_errors, samples_checked;
  localparam logic [15:0] CV [6] = '{16'he480, 16'hc350, 16'h0001, 16'hffff, 16'h8000, 16'h1234};
  // Channel, result, expected first alarm register
  localparam logic [26:0] AS [8] = '{{3'd0, 16'h1900, 8'h00}, {3'd0, 16'h1901, 8'h80},
    {3'd0, 16'hf5ff, 8'h40}, {3'd0, 16'h0000, 8'h00}, {3'd1, 16'h7fff, 8'h10},
    {3'd1, 16'hc001, 8'h20}, {3'd2, 16'h4001, 8'h28}, {3'd3, 16'h1fff, 8'h29}};
  msr_bank msr_bank_i (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_bus(bus), .o_rdata(rdata),
    .i_conv(conv), .i_thresh(thr), .i_tx_disable_pin(txd), .i_digital_input_one(in1),
    .i_rate_select_input(rate_select_input), .i_transmit_fault_drive_low(txf_lo),
    .i_loss_of_signal_drive_low(los_lo), .i_below_power_on_trip(below),
    .o_tx_disable_active(o_txd), .o_rate_select_output(o_rs));
  msr_host msr_host_i (.i_ref_clk(i_ref_clk), .i_rdata(rdata), .o_bus(bus));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    msr_host_i.rd(a, d);
    chk(d, exp);
  endtask : rc
  task automatic cv(input logic [2:0] ch, input logic [15:0] v, input logic cr);
    @(posedge i_ref_clk);
    conv <= '{1'b1, ch, v, cr};
    @(posedge i_ref_clk);
    conv <= '{1'b0, ~ch, ~v, ~cr};
  endtask : cv
  // Order: tx pin, input one, rate pin, fault low, los low, below trip
  task automatic pins(input logic [5:0] p);
    @(posedge i_ref_clk);
    {txd, in1, rate_select_input, txf_lo, los_lo, below} <= p;
    @(posedge i_ref_clk);
    #1;
  endtask : pins
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    for (int a = 'h60; a < 'h6e; a++) rc(8'(a), 8'h00);
    rc(MSR_OFF_STATUS, 8'h95);
    rc(MSR_OFF_UPDATE, 8'h00);
    rc(MSR_OFF_ALARM, 8'h10);
    $display("reset test done");
  endtask : t_reset
  task automatic t_status();
    pins(6'b010_100);
    rc(MSR_OFF_STATUS, 8'h22);
    chk({6'h0, o_txd, o_rs}, 8'h00);
    msr_host_i.wr(MSR_OFF_STATUS, 8'hff);
    rc(MSR_OFF_STATUS, 8'h6a);
    chk({6'h0, o_txd, o_rs}, 8'h03);
    pins(6'b101_011);
    rc(MSR_OFF_STATUS, 8'hdd);
    msr_host_i.wr(MSR_OFF_STATUS, 8'h00);
    #1;
    chk({6'h0, o_txd, o_rs}, 8'h03);
    pins(6'b000_110);
    rc(MSR_OFF_STATUS, 8'h00);
    chk({6'h0, o_txd, o_rs}, 8'h00);
    $display("status test done");
  endtask : t_status
  task automatic t_conv();
    for (int c = 0; c < 6; c++) begin
      cv(3'(c), CV[c], c == 4);
      msr_host_i.wr(8'('h60 + 2 * c), 8'h5a);
      rc(8'('h60 + 2 * c), CV[c][15:8]);
      rc(8'('h61 + 2 * c), CV[c][7:0]);
    end
    rc(MSR_OFF_UPDATE, 8'hfd);
    msr_host_i.wr(MSR_OFF_ALARM, 8'hff);
    rc(MSR_OFF_ALARM, 8'h00);
    $display("conversion test done");
  endtask : t_conv
  task automatic t_clear();
    logic [7:0] d;
    msr_host_i.wr(MSR_OFF_UPDATE, 8'h00);
    msr_host_i.rd(MSR_OFF_UPDATE, d);
    chk(d & 8'hfc, 8'h00);
    cv(MSR_CH_MONITOR_INPUT_THREE, 16'h0100, 1'b0);
    rc(MSR_OFF_UPDATE, 8'h08);
    $display("clear test done");
  endtask : t_clear
  task automatic t_alarm();
    logic [2:0] c;
    logic [15:0] v;
    logic [7:0] e;
    @(posedge i_ref_clk);
    thr[0] <= '{16'h1900, 16'hf600};
    thr[1] <= '{16'hc000, 16'h8000};
    thr[2] <= '{16'h4000, 16'h0000};
    thr[3] <= '{16'hffff, 16'h2000};
    for (int i = 0; i < 8; i++) begin
      {c, v, e} = AS[i];
      cv(c, v, 1'b0);
      rc(MSR_OFF_ALARM, e);
    end
    pins(6'b000_111);
    rc(MSR_OFF_ALARM, 8'h39);
    pins(6'b000_110);
    rc(MSR_OFF_ALARM, 8'h39);
    cv(MSR_CH_SUPPLY, 16'h8000, 1'b0);
    rc(MSR_OFF_ALARM, 8'h09);
    $display("alarm test done");
  endtask : t_alarm
  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report
  initial begin
    i_ref_clk = 1'b0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    repeat (5000) @(posedge i_ref_clk);
    num_errors++;
    final_report();
  end
  initial begin
    i_rstn = 1'b0;
    conv = '0;
    {txd, in1, rate_select_input, txf_lo, los_lo, below} = 6'b101_011;
    for (int i = 0; i < MSR_NCH; i++) thr[i] = '{16'hffff, 16'h0000};
    thr[0] = '{16'h7fff, 16'h8000};
    repeat (6) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    t_reset();
    t_status();
    t_conv();
    t_clear();
    t_alarm();
    final_report();
  end
endmodule : msr_bank_tb
